// >>> supply_voltage_detect_control.sv
// How it works
// - Unused control bits read zero, ignore writes
// - Stable flag reads settle state, resets zero
// - Power enable bit powers detector and reference
// - Three-bit level code picks one of eight thresholds
// - Level code resets to 100, 2.3 volts
// - Stable flag valid only with fast oscillator
// - Calibration word at 2009h survives bulk erase
// - Exactly eight trip points offered
// - Supply monitor raises interrupt event to core
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "supply_detect_cfg.svh"

module supply_voltage_detect_control #(
  parameter int ADDR_W = 12
) (
  input  wire  logic              core_clk,
  input  wire  logic              rst_n,
  // Avalon-MM slave
  input  wire  logic [ADDR_W-1:0] avs_address,
  input  wire  logic              avs_read,
  input  wire  logic              avs_write,
  input  wire  logic [31:0]       avs_writedata,
  input  wire  logic [3:0]        avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // Analog side
  input  wire  logic              supply_below_raw,
  input  wire  logic              ref_settled_raw,
  input  wire  logic              fast_osc_running_raw,
  output logic                    detector_power_enable,
  output logic [2:0]              detect_level_select,
  output logic [`CAL_W-1:0]       cal_trim,
  // Configuration programming port
  input  wire  logic              prog_we,
  input  wire  logic [13:0]       prog_addr,
  input  wire  logic [`CAL_W-1:0] prog_data,
  input  wire  logic              bulk_erase,
  // Interrupt
  output logic                    irq
);

  // Word index of a byte address
  function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr);
    return wide[11:2];
  endfunction

  // Nominal trip point in millivolts for a level code
  function automatic logic [15:0] trip_mv(input logic [2:0] code);
    logic [15:0] mv;
    mv = `MV_CODE0;
    unique case (code)
      3'h7: mv = `MV_CODE7;
      3'h6: mv = `MV_CODE6;
      3'h5: mv = `MV_CODE5;
      3'h4: mv = `MV_CODE4;
      3'h3: mv = `MV_CODE3;
      3'h2: mv = `MV_CODE2;
      3'h1: mv = `MV_CODE1;
      3'h0: mv = `MV_CODE0;
    endcase
    return mv;
  endfunction

  // Register state
  supply_detect_pkg::bus_phase_t phase_q;
  supply_detect_pkg::event_t     status_q;
  supply_detect_pkg::event_t     evt_en_q;
  supply_detect_pkg::event_t     evt_set;
  supply_detect_pkg::event_t     evt_clr;
  supply_detect_pkg::ctrl_reg_t  ctrl_view;
  logic                          en_q;
  logic [2:0]                    level_q;
  logic [`CAL_W-1:0]             cal_q;
  logic [31:0]                   readdata_q;
  logic [2:0]                    sync1_q;
  logic [2:0]                    sync2_q;
  logic                          below_prev_q;
  logic                          stable_prev_q;
  logic                          below_s;
  logic                          settled_s;
  logic                          osc_s;
  logic                          stable_flag;
  // Bus decode and write strobes
  logic                          req;
  logic                          accept;
  logic [9:0]                    idx;
  logic                          wr_ctrl;
  logic                          wr_clear;
  logic                          wr_enable;

  // Two-flop synchronisers for the analog and oscillator levels
  // A level that flips near an edge may take one extra cycle to show
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {fast_osc_running_raw, ref_settled_raw, supply_below_raw};
      sync2_q <= sync1_q;
    end
  end

  assign below_s   = sync2_q[0];
  assign settled_s = sync2_q[1];
  assign osc_s     = sync2_q[2];

  // Settled state only means something on the fast oscillator, so it is
  // masked otherwise rather than showing a value software could misread
  assign stable_flag = en_q & settled_s & osc_s;

  // Bus handshake: one wait cycle, answer on the second
  assign req             = avs_read | avs_write;
  assign accept          = req & (phase_q == supply_detect_pkg::BUS_ACK);
  assign avs_waitrequest = req & (phase_q == supply_detect_pkg::BUS_IDLE);
  assign idx             = word_index(avs_address);

  // Phase returns to idle after every answer, so a request held high
  // straight into the next one costs a wait cycle again
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_q <= supply_detect_pkg::BUS_IDLE;
    end else if (req && phase_q == supply_detect_pkg::BUS_IDLE) begin
      phase_q <= supply_detect_pkg::BUS_ACK;
    end else begin
      phase_q <= supply_detect_pkg::BUS_IDLE;
    end
  end

  // Write strobes, low byte lane only carries register bits
  assign wr_ctrl   = accept & avs_write & avs_byteenable[0] & (idx == `CTRL_IDX);
  assign wr_clear  = accept & avs_write & avs_byteenable[0] & (idx == `CLEAR_IDX);
  assign wr_enable = accept & avs_write & avs_byteenable[0] & (idx == `ENABLE_IDX);

  // Control register: only enable and level are writable
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_q    <= `CTRL_EN_RST;
      level_q <= `CTRL_LEVEL_RST;
    end else if (wr_ctrl) begin
      en_q    <= avs_writedata[`CTRL_EN_BIT];
      level_q <= avs_writedata[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB];
    end
  end

  // Powering down drops the reference too; the analog side sees both
  assign detector_power_enable = en_q;
  assign detect_level_select   = level_q;

  // Readback view with unused positions tied low
  always_comb begin
    ctrl_view                       = '0;
    ctrl_view.reference_stable_flag = stable_flag;
    ctrl_view.detector_power_enable = en_q;
    ctrl_view.detect_level_select   = level_q;
  end

  // Calibration word: only reset, which loads zero, or a targeted program write changes it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cal_q <= `CAL_RST;
    end else if (prog_we && prog_addr == `CAL_WORD_ADDR) begin
      cal_q <= prog_data;
    end
  end

  // Bulk erase is deliberately not a term here, so trim values persist
  assign cal_trim = cal_q;

  // Edge history for event detection; both flops reset low, the idle level
  // of their sources, so leaving reset never looks like a rising edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      below_prev_q  <= 1'h0;
      stable_prev_q <= 1'h0;
    end else begin
      below_prev_q  <= below_s;
      stable_prev_q <= stable_flag;
    end
  end

  // Low supply counts only while powered and settled
  always_comb begin
    evt_set            = '0;
    evt_set.supply_low = stable_flag & below_s & ~below_prev_q;
    evt_set.ref_stable = stable_flag & ~stable_prev_q;
    evt_clr            = '0;
    if (wr_clear) begin
      evt_clr = avs_writedata[`EVT_W-1:0];
    end
  end

  // Sticky status: a set in the same cycle as its clear wins
  // Clear is write-one; a zero in the clear word leaves that bit alone
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_q <= `EVT_RST;
    end else begin
      status_q <= (status_q & ~evt_clr) | evt_set;
    end
  end

  // Interrupt enable register
  // Enables only gate the output; status bits latch regardless
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      evt_en_q <= `EVT_RST;
    end else if (wr_enable) begin
      evt_en_q <= avs_writedata[`EVT_W-1:0];
    end
  end

  // Level interrupt, high while any enabled status bit is set
  assign irq = |(status_q & evt_en_q);

  // Read data captured in the wait cycle so it stands with the answer;
  // unmapped and write-only words read zero
  // The threshold word is informational; the comparator itself is analog
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readdata_q <= 32'h0000_0000;
    end else if (avs_read && phase_q == supply_detect_pkg::BUS_IDLE) begin
      readdata_q <= 32'h0000_0000;
      if (idx == `CTRL_IDX) begin
        readdata_q <= 32'(ctrl_view);
      end else if (idx == `STATUS_IDX) begin
        readdata_q <= 32'(status_q);
      end else if (idx == `ENABLE_IDX) begin
        readdata_q <= 32'(evt_en_q);
      end else if (idx == `CAL_IDX) begin
        readdata_q <= 32'(cal_q);
      end else if (idx == `THRESH_IDX) begin
        readdata_q <= 32'(trip_mv(level_q));
      end
    end
  end

  assign avs_readdata = readdata_q;

  // Checks sit with the logic they guard; reset masks them all except the
  // reset-value check, which has to look at reset itself
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_RSVD_ZERO: assert property (
    (avs_read && accept && idx == `CTRL_IDX) |-> (avs_readdata[7:6] == 2'h0 && avs_readdata[3] == 1'h0)
  ) else $error("Unused control bits read nonzero");

  AST_STABLE_OFF: assert property (
    !en_q |-> !ctrl_view.reference_stable_flag
  ) else $error("Stable flag set while detector off");

  AST_POWER_WRITE: assert property (
    wr_ctrl |=> detector_power_enable == $past(avs_writedata[`CTRL_EN_BIT])
  ) else $error("Power enable did not follow write");

  AST_LEVEL_WRITE: assert property (
    wr_ctrl |=> detect_level_select == $past(avs_writedata[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB])
  ) else $error("Level select did not follow write");

  AST_LEVEL_RESET: assert property (
    @(posedge core_clk) disable iff (1'b0)
      !rst_n |=> (detect_level_select == `CTRL_LEVEL_RST && detector_power_enable == `CTRL_EN_RST)
  ) else $error("Reset level is not code 100");

  AST_OSC_GATE: assert property (
    !osc_s |-> !stable_flag
  ) else $error("Stable flag shown without fast oscillator");

  AST_CAL_KEEP: assert property (
    (bulk_erase && !prog_we) |=> $stable(cal_trim)
  ) else $error("Calibration word changed by erase");

  AST_LOW_EVENT: assert property (
    (stable_flag && below_s && !below_prev_q) |=> (status_q.supply_low && (irq || !evt_en_q.supply_low))
  ) else $error("Low supply event not latched");

  AST_NO_FLAG_OFF: assert property (
    (!en_q && !wr_ctrl && !status_q.supply_low) |=> !status_q.supply_low
  ) else $error("Flag raised while detector disabled");

  AST_BUS_ANSWER: assert property (
    (req && phase_q == supply_detect_pkg::BUS_IDLE) |-> avs_waitrequest ##1 (!req || !avs_waitrequest)
  ) else $error("Bus answer not after one wait cycle");

  // Write path and readback
  AST_CTRL_KEEP_BE: assert property (
    (accept && avs_write && !avs_byteenable[0]) |=> ($stable(en_q) && $stable(level_q))
  ) else $error("Control changed by write without low byte lane");

  AST_CTRL_READBACK: assert property (
    (accept && avs_read && idx == `CTRL_IDX) |->
      (avs_readdata[`CTRL_EN_BIT] == en_q && avs_readdata[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB] == level_q)
  ) else $error("Control readback differs from register");

  AST_UNMAPPED_ZERO: assert property (
    (accept && avs_read && (idx < `CTRL_IDX || idx > `THRESH_IDX)) |-> avs_readdata == 32'h0000_0000
  ) else $error("Unmapped word read nonzero");

  AST_PHASE_RETURN: assert property (
    accept |=> phase_q == supply_detect_pkg::BUS_IDLE
  ) else $error("Bus phase stuck after answer");

  // Settling and event latching
  AST_STABLE_SETTLED: assert property (
    !settled_s |-> !stable_flag
  ) else $error("Stable flag shown before reference settled");

  AST_STABLE_RISE: assert property (
    (stable_flag && !stable_prev_q) |=> status_q.ref_stable
  ) else $error("Reference settle event not latched");

  AST_SET_WINS: assert property (
    evt_set.supply_low |=> status_q.supply_low
  ) else $error("Low supply set lost to a clear");

  AST_STICKY_LOW: assert property (
    (status_q.supply_low && !wr_clear) |=> status_q.supply_low
  ) else $error("Low supply flag dropped without clear");

  AST_CLEAR_LOW: assert property (
    (wr_clear && avs_writedata[`EVT_LOW_BIT] && !evt_set.supply_low) |=> !status_q.supply_low
  ) else $error("Low supply flag survived its clear");

  AST_IRQ_MASKED: assert property (
    (evt_en_q == '0) |-> !irq
  ) else $error("Interrupt raised with all enables off");

  // Calibration word
  AST_CAL_PROGRAM: assert property (
    (prog_we && prog_addr == `CAL_WORD_ADDR) |=> cal_trim == $past(prog_data)
  ) else $error("Calibration word not written");

  AST_CAL_OTHER: assert property (
    !(prog_we && prog_addr == `CAL_WORD_ADDR) |=> $stable(cal_trim)
  ) else $error("Calibration word changed without its write");

  COV_LOW_IRQ: cover property (evt_en_q.supply_low && status_q.supply_low ##1 irq);
  COV_CTRL_READ: cover property (accept && avs_read && idx == `CTRL_IDX && avs_readdata[5]);
  COV_SET_CLEAR: cover property (wr_clear && evt_set.supply_low);
  COV_STABLE_EVENT: cover property (evt_set.ref_stable);
  COV_CAL_WRITE: cover property (prog_we && prog_addr == `CAL_WORD_ADDR);

endmodule // supply_voltage_detect_control

`default_nettype wire

// >>> supply_detect_cfg.svh
`ifndef SUPPLY_DETECT_CFG_SVH
`define SUPPLY_DETECT_CFG_SVH

// Register indices; byte address is four times the index
`define CTRL_IDX       10'h109
`define STATUS_IDX     10'h10a
`define CLEAR_IDX      10'h10b
`define ENABLE_IDX     10'h10c
`define CAL_IDX        10'h10d
`define THRESH_IDX     10'h10e

// Control register fields
`define CTRL_STABLE_BIT  5
`define CTRL_EN_BIT      4
`define CTRL_LEVEL_MSB   2
`define CTRL_LEVEL_LSB   0
`define CTRL_EN_RST      1'h0
`define CTRL_LEVEL_RST   3'h4

// Event bits of status, clear and enable registers
`define EVT_LOW_BIT      0
`define EVT_STABLE_BIT   1
`define EVT_W            2
`define EVT_RST          2'h0

// Calibration word location in the configuration space
`define CAL_WORD_ADDR    14'h2009
`define CAL_W            14
`define CAL_RST          14'h0000

// Nominal trip points in millivolts, one per level code
`define MV_CODE7  16'h1194
`define MV_CODE6  16'h1068
`define MV_CODE5  16'h0fa0
`define MV_CODE4  16'h08fc
`define MV_CODE3  16'h0898
`define MV_CODE2  16'h0834
`define MV_CODE1  16'h07d0
`define MV_CODE0  16'h076c

`endif

// >>> supply_detect_pkg.sv
`default_nettype none

package supply_detect_pkg;

  // Layout of the 8-bit control register
  typedef struct packed {
    logic [1:0] unused_hi;
    logic       reference_stable_flag;
    logic       detector_power_enable;
    logic       unused_mid;
    logic [2:0] detect_level_select;
  } ctrl_reg_t;

  // Sticky detector events
  typedef struct packed {
    logic ref_stable;
    logic supply_low;
  } event_t;

  // Bus access phases
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_phase_t;

endpackage

`default_nettype wire

// >>> supply_voltage_detect_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "supply_detect_cfg.svh"

module supply_voltage_detect_control_tb_top;
  logic              core_clk;
  logic              rst_n;
  logic [11:0]       avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              supply_below_raw;
  logic              ref_settled_raw;
  logic              fast_osc_running_raw;
  logic              detector_power_enable;
  logic [2:0]        detect_level_select;
  logic [`CAL_W-1:0] cal_trim;
  logic              prog_we;
  logic [13:0]       prog_addr;
  logic [`CAL_W-1:0] prog_data;
  logic              bulk_erase;
  logic              irq;
  int                error_cnt;
  int                total_checks;
  logic [31:0]       rd;
  // Nominal trip points in millivolts, code 0 first
  logic [31:0]       mv_tab [0:7] = '{32'h076c, 32'h07d0, 32'h0834, 32'h0898,
                                      32'h08fc, 32'h0fa0, 32'h1068, 32'h1194};

  supply_voltage_detect_control supply_voltage_detect_control_inst (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .supply_below_raw(supply_below_raw), .ref_settled_raw(ref_settled_raw),
    .fast_osc_running_raw(fast_osc_running_raw), .detector_power_enable(detector_power_enable),
    .detect_level_select(detect_level_select), .cal_trim(cal_trim), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data), .bulk_erase(bulk_erase), .irq(irq));

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access; the request stands until the rising edge at which
  // waitrequest is seen low, and read data is taken at that same edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd, input logic [3:0] be);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    while (!done && n < 50) begin
      @(posedge core_clk);
      n++;
      done = (avs_waitrequest === 1'b0);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
    if (!done) begin
      error_cnt++;
      $display("BAD %0t bus answer never came", $time);
      summarize();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd, 4'h1);
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, 4'hf);
    check(rd, exp);
  endtask

  // Poll a register for an expected value under a bounded count of reads
  task automatic wait_val(input logic [9:0] idx, input logic [31:0] exp);
    int n;
    n = 0;
    bus(1'b0, idx, 32'h0, 4'hf);
    while (rd !== exp && n < 20) begin
      bus(1'b0, idx, 32'h0, 4'hf);
      n++;
    end
    check(rd, exp);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("BAD %0t run did not finish", $time);
    summarize();
  end

  initial begin
    rst_n = 1'b0; avs_address = 12'h000; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'h0; supply_below_raw = 1'b0;
    ref_settled_raw = 1'b0; fast_osc_running_raw = 1'b0; prog_we = 1'b0;
    prog_addr = 14'h0000; prog_data = 14'h0000; bulk_erase = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdchk(`CTRL_IDX, 32'h04);
    check({28'h0, detector_power_enable, detect_level_select}, 32'h4);
    rdchk(`STATUS_IDX, 32'h0);
    // Every writable and unused bit set at once
    wr(`CTRL_IDX, 32'hff);
    rdchk(`CTRL_IDX, 32'h17);
    check({28'h0, detector_power_enable, detect_level_select}, 32'hf);
    for (int i = 0; i < 8; i++) begin
      wr(`CTRL_IDX, 32'(i));
      rdchk(`CTRL_IDX, 32'(i));
      check({29'h0, detect_level_select}, 32'(i));
      rdchk(`THRESH_IDX, mv_tab[i]);
    end
    // Refused accesses leave state alone
    bus(1'b1, `CTRL_IDX, 32'h13, 4'h0);
    rdchk(`CTRL_IDX, 32'h07);
    bus(1'b1, 10'h3ff, 32'hff, 4'hf);
    rdchk(10'h3ff, 32'h0);
    rdchk(`CLEAR_IDX, 32'h0);
    // Settled reference without the fast oscillator must not read stable
    ref_settled_raw <= 1'b1;
    wr(`CTRL_IDX, 32'h14);
    repeat (8) @(posedge core_clk);
    rdchk(`CTRL_IDX, 32'h14);
    fast_osc_running_raw <= 1'b1;
    wait_val(`CTRL_IDX, 32'h34);
    wait_val(`STATUS_IDX, 32'h2);
    wr(`ENABLE_IDX, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(`CLEAR_IDX, 32'h2);
    rdchk(`STATUS_IDX, 32'h0);
    check({31'h0, irq}, 32'h0);
    // Supply drop while powered and settled, then mask and clear
    wr(`ENABLE_IDX, 32'h1);
    supply_below_raw <= 1'b1;
    wait_val(`STATUS_IDX, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(`ENABLE_IDX, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(`CLEAR_IDX, 32'h1);
    rdchk(`STATUS_IDX, 32'h0);
    supply_below_raw <= 1'b0;
    // Powered down: no stable reading and no supply event
    wr(`CTRL_IDX, 32'h04);
    repeat (6) @(posedge core_clk);
    rdchk(`CTRL_IDX, 32'h04);
    check({31'h0, detector_power_enable}, 32'h0);
    supply_below_raw <= 1'b1;
    repeat (8) @(posedge core_clk);
    rdchk(`STATUS_IDX, 32'h0);
    wr(`ENABLE_IDX, 32'h3);
    check({31'h0, irq}, 32'h0);
    supply_below_raw <= 1'b0;
    // Calibration word: only its own address writes it, erase leaves it
    prog_addr <= `CAL_WORD_ADDR;
    prog_data <= 14'h01a5;
    prog_we <= 1'b1;
    @(posedge core_clk);
    prog_we <= 1'b0;
    @(posedge core_clk);
    check({18'h0, cal_trim}, 32'h01a5);
    prog_addr <= 14'h2008;
    prog_data <= 14'h3fff;
    prog_we <= 1'b1;
    @(posedge core_clk);
    prog_we <= 1'b0;
    bulk_erase <= 1'b1;
    @(posedge core_clk);
    bulk_erase <= 1'b0;
    @(posedge core_clk);
    rdchk(`CAL_IDX, 32'h01a5);
    // Mid-run reset brings control and enables back to their defaults
    wr(`CTRL_IDX, 32'h13);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdchk(`CTRL_IDX, 32'h04);
    rdchk(`ENABLE_IDX, 32'h0);
    check({31'h0, irq}, 32'h0);
    summarize();
  end
endmodule // supply_voltage_detect_control_tb_top
`default_nettype wire
